// ---- dsm_pkg.sv ----
// Operation
// - status word: ready, running, fault, line, alarm, network, reference, keypad stop, direction
// - one status word layout for both the simple and drive profiles
// - state changes on command or internal event; state decodable from status word
// - not-ready-to-switch-on is transient and never reported
// - disabled and ready states: output locked, no contactor, configuration accepted
// - ready to switched on only with power line supply present
// - switched on: line supply needed, contactor driven, stage ready, configuration and adjustments accepted
// - configuration write in switched on returns to switch-on disabled
// - operation enabled: output unlocked, motor powered, adjustments only
// - open loop with zero reference or halt: no motor power
// - auto-tuning runs only in operation enabled
// - enable operation needs valid channel and first reference when shared
// - disable operation, option 0: straight to switched on, motor coasts
// - disable operation, option 1: ramp down first, then switched on
// - quick stop: fast stop powered, no configuration, restart via disabled
// - quick stop option 2: fast ramp then automatic switch-on disabled
// - quick stop option 6: hold until disable voltage, keypad or freewheel stop
// - fault passes through transient reaction state, then locks in fault
package dsm_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned INIT_TIME_NS  = 400;
  localparam int unsigned INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_CNT_W    = 5;

  // ----------------------------------------
  // status word fields
  // ----------------------------------------
  localparam int unsigned SW_BIT_ARMED   = 0;
  localparam int unsigned SW_BIT_READY   = 1;
  localparam int unsigned SW_BIT_RUN     = 2;
  localparam int unsigned SW_BIT_FAULT   = 3;
  localparam int unsigned SW_BIT_LINE    = 4;
  localparam int unsigned SW_BIT_ONE     = 5;
  localparam int unsigned SW_BIT_DISABLE = 6;
  localparam int unsigned SW_BIT_ALARM   = 7;
  localparam int unsigned SW_BIT_NET     = 9;
  localparam int unsigned SW_BIT_LIMIT   = 10;
  localparam int unsigned SW_BIT_REFOK   = 11;
  localparam int unsigned SW_BIT_KEYSTOP = 14;
  localparam int unsigned SW_BIT_DIR     = 15;
  localparam logic [15:0] SW_RESET       = 16'h0020;

  // ----------------------------------------
  // command word fields
  // ----------------------------------------
  localparam int unsigned CW_BIT_SWITCH_ON = 0;
  localparam int unsigned CW_BIT_VOLTAGE   = 1;
  localparam int unsigned CW_BIT_QSTOP_N   = 2;
  localparam int unsigned CW_BIT_ENABLE_OP = 3;
  localparam int unsigned CW_BIT_FRESET    = 7;
  localparam logic [15:0] CW_RESET         = 16'h0000;

  // ----------------------------------------
  // option codes
  // ----------------------------------------
  localparam logic       DISOP_COAST = 1'b0;
  localparam logic       DISOP_RAMP  = 1'b1;
  localparam logic [2:0] QSOPT_AUTO  = 3'h2;
  localparam logic [2:0] QSOPT_HOLD  = 3'h6;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [7:0] {
    DSM_NOT_READY   = 8'h01,
    DSM_SW_ON_DIS   = 8'h02,
    DSM_READY       = 8'h04,
    DSM_SWITCHED_ON = 8'h08,
    DSM_OP_ENABLED  = 8'h10,
    DSM_QUICK_STOP  = 8'h20,
    DSM_FAULT_REACT = 8'h40,
    DSM_FAULT       = 8'h80
  } dsm_state_t;

  typedef struct packed {
    logic shutdown;
    logic switch_on;
    logic enable_op;
    logic disable_voltage;
    logic quick_stop;
    logic fault_reset;
  } dsm_cmd_t;

  typedef struct packed {
    logic line_supply;
    logic alarm;
    logic net_control;
    logic ref_limit;
    logic ref_reached;
    logic keypad_stop;
    logic dir_reverse;
  } dsm_flags_t;

endpackage

// ---- dsm_cmd_decode.sv ----
module dsm_cmd_decode (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_b,
  // command word from the master
  input  wire logic              cmd_load,
  input  wire logic [15:0]       cmd_word,
  // decoded commands
  output dsm_pkg::dsm_cmd_t      cmd
);
  import dsm_pkg::*;

  logic [15:0] word_q;
  logic        freset_prev_q;
  logic        sw_on;
  logic        volt;
  logic        qs_n;
  logic        en_op;

  // ----------------------------------------
  // latch: the word holds until rewritten
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= CW_RESET;
    end else if (cmd_load) begin
      word_q <= cmd_word;
    end
  end

  // edge memory so a held bit 7 resets only once
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      freset_prev_q <= 1'b0;
    end else begin
      freset_prev_q <= word_q[CW_BIT_FRESET];
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign sw_on = word_q[CW_BIT_SWITCH_ON];
  assign volt  = word_q[CW_BIT_VOLTAGE];
  assign qs_n  = word_q[CW_BIT_QSTOP_N];
  assign en_op = word_q[CW_BIT_ENABLE_OP];

  always_comb begin
    cmd.disable_voltage = !volt;
    cmd.quick_stop      = volt && !qs_n;
    cmd.shutdown        = volt && qs_n && !sw_on;
    cmd.switch_on       = volt && qs_n && sw_on && !en_op;
    cmd.enable_op       = volt && qs_n && sw_on && en_op;
    cmd.fault_reset     = word_q[CW_BIT_FRESET] && !freset_prev_q;
  end

endmodule

// ---- dsm_status_word.sv ----
module dsm_status_word (
  // state and plant flags
  input  dsm_pkg::dsm_state_t    state,
  input  dsm_pkg::dsm_flags_t    flags,
  // assembled word
  output logic [15:0]            word
);
  import dsm_pkg::*;

  // ----------------------------------------
  // layout shared by both profiles
  // ----------------------------------------
  always_comb begin
    word = 16'h0000;
    word[SW_BIT_ONE]     = 1'b1;
    word[SW_BIT_LINE]    = flags.line_supply;
    word[SW_BIT_ALARM]   = flags.alarm;
    word[SW_BIT_NET]     = flags.net_control;
    word[SW_BIT_LIMIT]   = flags.ref_limit;
    word[SW_BIT_REFOK]   = flags.ref_reached;
    word[SW_BIT_KEYSTOP] = flags.keypad_stop;
    word[SW_BIT_DIR]     = flags.dir_reverse;
    // state code; init shows as disabled, never as itself
    unique case (state)
      DSM_NOT_READY,
      DSM_SW_ON_DIS: begin
        word[SW_BIT_DISABLE] = 1'b1;
      end
      DSM_READY: begin
        word[SW_BIT_ARMED] = 1'b1;
      end
      DSM_SWITCHED_ON: begin
        word[SW_BIT_ARMED] = 1'b1;
        word[SW_BIT_READY] = 1'b1;
      end
      DSM_OP_ENABLED: begin
        word[SW_BIT_ARMED] = 1'b1;
        word[SW_BIT_READY] = 1'b1;
        word[SW_BIT_RUN]   = 1'b1;
      end
      DSM_QUICK_STOP: begin
        word[SW_BIT_ARMED]   = 1'b1;
        word[SW_BIT_READY]   = 1'b1;
        word[SW_BIT_RUN]     = 1'b1;
        word[SW_BIT_DISABLE] = 1'b1;
      end
      DSM_FAULT_REACT: begin
        word[SW_BIT_ARMED] = 1'b1;
        word[SW_BIT_READY] = 1'b1;
        word[SW_BIT_RUN]   = 1'b1;
        word[SW_BIT_FAULT] = 1'b1;
      end
      DSM_FAULT: begin
        word[SW_BIT_FAULT] = 1'b1;
      end
      default: begin
        word[SW_BIT_FAULT] = 1'b1;
      end
    endcase
  end

endmodule

// ---- dsm_drive_state_machine.sv ----
module dsm_drive_state_machine (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_b,
  // command word from the master
  input  wire logic               cmd_load,
  input  wire logic [15:0]        cmd_word,
  // command channel state
  input  wire logic               channel_valid,
  input  wire logic               ref_shared,
  input  wire logic               ref_received,
  // plant flags for the status word
  input  dsm_pkg::dsm_flags_t     flags,
  // internal events
  input  wire logic               fault_event,
  input  wire logic               fault_react_done,
  input  wire logic               speed_zero,
  input  wire logic               freewheel_stop,
  // open-loop conditions
  input  wire logic               open_loop,
  input  wire logic               reference_zero,
  input  wire logic               halt,
  // options and parameter access
  input  wire logic               disable_op_option,
  input  wire logic [2:0]         quickstop_option,
  input  wire logic               cfg_write,
  input  wire logic               adj_write,
  input  wire logic               autotune_request,
  // status
  output logic [15:0]             drive_state_word,
  output dsm_pkg::dsm_state_t     state,
  // power section control
  output logic                    output_unlocked,
  output logic                    motor_power,
  output logic                    contactor_drive,
  output logic                    power_stage_ready,
  output logic                    drive_func_active,
  // stop requests
  output logic                    ramp_stop,
  output logic                    fast_stop,
  output logic                    coast_stop,
  // parameter access answers
  output logic                    cfg_write_ok,
  output logic                    adj_write_ok,
  output logic                    autotune_start
);
  import dsm_pkg::*;

  dsm_state_t            state_q;
  dsm_state_t            state_d;
  dsm_cmd_t              cmd;
  logic [15:0]           word_d;
  logic [15:0]           drive_state_word_q;
  logic [INIT_CNT_W-1:0] init_cnt_q;
  logic                  init_done;
  logic                  op_allowed;
  logic                  disable_op;
  logic                  ramp_active;
  logic                  qs_leave;
  logic                  fault_entry;
  logic                  cfg_state;
  logic                  adj_state;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  dsm_cmd_decode u_decode (
    .clock    (clock),
    .rst_b    (rst_b),
    .cmd_load (cmd_load),
    .cmd_word (cmd_word),
    .cmd      (cmd)
  );

  // ----------------------------------------
  // initialization timer
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_q <= '0;
    end else if (state_q == DSM_NOT_READY && !init_done) begin
      init_cnt_q <= init_cnt_q + INIT_CNT_W'(1);
    end
  end

  assign init_done = (init_cnt_q == INIT_CNT_W'(INIT_CYCLES - 1));

  // ----------------------------------------
  // transition qualifiers
  // ----------------------------------------
  // first reference gates enable only when it shares the channel
  assign op_allowed  = channel_valid && (!ref_shared || ref_received);
  // same word as switch on, read as disable while running
  assign disable_op  = cmd.switch_on;
  assign ramp_active = (state_q == DSM_OP_ENABLED) && disable_op
                       && (disable_op_option == DISOP_RAMP);
  // any code other than hold behaves as auto return
  assign qs_leave    = cmd.disable_voltage || flags.keypad_stop || freewheel_stop
                       || (quickstop_option != QSOPT_HOLD && speed_zero);
  // init, reaction and fault itself ignore new fault events
  assign fault_entry = fault_event && (state_q != DSM_NOT_READY)
                       && (state_q != DSM_FAULT_REACT) && (state_q != DSM_FAULT);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    if (fault_entry) begin
      state_d = DSM_FAULT_REACT;
    end else begin
      unique case (state_q)
        DSM_NOT_READY: begin
          if (init_done) begin
            state_d = DSM_SW_ON_DIS;
          end
        end
        DSM_SW_ON_DIS: begin
          if (cmd.shutdown) begin
            state_d = DSM_READY;
          end
        end
        DSM_READY: begin
          if (cmd.disable_voltage || cmd.quick_stop) begin
            state_d = DSM_SW_ON_DIS;
          end else if ((cmd.switch_on || cmd.enable_op) && flags.line_supply) begin
            state_d = DSM_SWITCHED_ON;
          end
        end
        DSM_SWITCHED_ON: begin
          if (cfg_write) begin
            state_d = DSM_SW_ON_DIS;
          end else if (cmd.disable_voltage || cmd.quick_stop) begin
            state_d = DSM_SW_ON_DIS;
          end else if (cmd.shutdown || !flags.line_supply) begin
            state_d = DSM_READY;
          end else if (cmd.enable_op && op_allowed) begin
            state_d = DSM_OP_ENABLED;
          end
        end
        DSM_OP_ENABLED: begin
          if (cmd.disable_voltage || freewheel_stop) begin
            state_d = DSM_SW_ON_DIS;
          end else if (cmd.quick_stop) begin
            state_d = DSM_QUICK_STOP;
          end else if (cmd.shutdown || !flags.line_supply) begin
            state_d = DSM_READY;
          end else if (disable_op && disable_op_option == DISOP_COAST) begin
            state_d = DSM_SWITCHED_ON;
          end else if (ramp_active && speed_zero) begin
            state_d = DSM_SWITCHED_ON;
          end
        end
        DSM_QUICK_STOP: begin
          // apart from a fault, only exit is switch-on disabled, so restart goes the long way
          if (qs_leave) begin
            state_d = DSM_SW_ON_DIS;
          end
        end
        DSM_FAULT_REACT: begin
          if (fault_react_done) begin
            state_d = DSM_FAULT;
          end
        end
        DSM_FAULT: begin
          if (cmd.fault_reset) begin
            state_d = DSM_SW_ON_DIS;
          end
        end
        default: begin
          state_d = DSM_NOT_READY;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state and status registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= DSM_NOT_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // word built from the next state so both land on one edge
  dsm_status_word u_status (
    .state (state_d),
    .flags (flags),
    .word  (word_d)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      drive_state_word_q <= SW_RESET;
    end else begin
      drive_state_word_q <= word_d;
    end
  end

  assign drive_state_word = drive_state_word_q;
  assign state            = state_q;

  // ----------------------------------------
  // power section control
  // ----------------------------------------
  // disabled and ready keep everything off
  always_comb begin
    output_unlocked   = 1'b0;
    motor_power       = 1'b0;
    contactor_drive   = 1'b0;
    power_stage_ready = 1'b0;
    drive_func_active = 1'b0;
    unique case (state_q)
      DSM_SWITCHED_ON: begin
        contactor_drive   = 1'b1;
        power_stage_ready = 1'b1;
      end
      DSM_OP_ENABLED: begin
        contactor_drive   = 1'b1;
        power_stage_ready = 1'b1;
        output_unlocked   = 1'b1;
        drive_func_active = 1'b1;
        motor_power       = !(open_loop && (reference_zero || halt));
      end
      DSM_QUICK_STOP: begin
        // powered only while the fast ramp is still running
        contactor_drive   = 1'b1;
        power_stage_ready = 1'b1;
        output_unlocked   = !speed_zero;
        motor_power       = !speed_zero;
      end
      default: begin
        output_unlocked = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // stop requests
  // ----------------------------------------
  assign ramp_stop  = ramp_active;
  assign fast_stop  = (state_q == DSM_QUICK_STOP) && !speed_zero;
  // coast lasts one cycle: the state has moved on by the next edge
  assign coast_stop = (state_q == DSM_OP_ENABLED) && !fault_entry && !cmd.disable_voltage
                      && !cmd.quick_stop && !cmd.shutdown && disable_op
                      && disable_op_option == DISOP_COAST && !freewheel_stop
                      && flags.line_supply;

  // ----------------------------------------
  // parameter access
  // ----------------------------------------
  // switched on takes configuration too, but pays with a state drop
  assign cfg_state = (state_q == DSM_SW_ON_DIS) || (state_q == DSM_READY)
                     || (state_q == DSM_SWITCHED_ON) || (state_q == DSM_FAULT);
  assign adj_state = cfg_state || (state_q == DSM_OP_ENABLED);

  assign cfg_write_ok   = cfg_write && cfg_state;
  assign adj_write_ok   = adj_write && adj_state;
  // tuning drives current, so it needs an unlocked output
  assign autotune_start = autotune_request && (state_q == DSM_OP_ENABLED);

endmodule

// ---- dsm_drive_state_machine_assertions.sv ----
module dsm_drive_state_machine_checker (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst_b,
  // watched inputs
  input  dsm_pkg::dsm_flags_t flags,
  input  wire logic          fault_event,
  input  wire logic          speed_zero,
  input  wire logic          freewheel_stop,
  input  wire logic          open_loop,
  input  wire logic          reference_zero,
  input  wire logic          halt,
  input  wire logic [2:0]    quickstop_option,
  input  wire logic          cfg_write,
  input  wire logic          autotune_request,
  // watched outputs
  input  wire logic [15:0]   drive_state_word,
  input  dsm_pkg::dsm_state_t state,
  input  wire logic          output_unlocked,
  input  wire logic          motor_power,
  input  wire logic          contactor_drive,
  input  wire logic          ramp_stop,
  input  wire logic          cfg_write_ok,
  input  wire logic          autotune_start
);
  import dsm_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] code_of(dsm_state_t s);
    case (s)
      DSM_SW_ON_DIS:   return 16'h0040;
      DSM_READY:       return 16'h0001;
      DSM_SWITCHED_ON: return 16'h0003;
      DSM_OP_ENABLED:  return 16'h0007;
      DSM_QUICK_STOP:  return 16'h0047;
      DSM_FAULT_REACT: return 16'h000F;
      default:         return 16'h0008;
    endcase
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_fault_hit;
    fault_event && !(state inside {DSM_NOT_READY, DSM_FAULT_REACT, DSM_FAULT});
  endsequence
  sequence s_qs_settled;
    state == DSM_QUICK_STOP && quickstop_option != QSOPT_HOLD && speed_zero && !fault_event;
  endsequence
  sequence s_disabled;
    state == DSM_SW_ON_DIS;
  endsequence

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_FIXED_BITS: assert property (
    drive_state_word[5] && !drive_state_word[8] && drive_state_word[13:12] == 2'b00)
    else $error("fixed status bits wrong");
  AST_INIT_HIDDEN: assert property (
    (state == DSM_NOT_READY)[*2] |-> (drive_state_word & 16'h004F) == 16'h0040)
    else $error("init state visible");
  AST_INIT_LEAVE: assert property (state == DSM_NOT_READY |-> ##[1:18] s_disabled)
    else $error("init not left");
  AST_STATE_CODE: assert property (
    state != DSM_NOT_READY |-> (drive_state_word & 16'h004F) == code_of(state))
    else $error("status code differs from state");
  AST_LOCKED: assert property (
    state inside {DSM_SW_ON_DIS, DSM_READY, DSM_SWITCHED_ON, DSM_FAULT} |-> !output_unlocked && !motor_power)
    else $error("output unlocked in locked state");
  AST_CONTACTOR: assert property (
    state inside {DSM_SW_ON_DIS, DSM_READY, DSM_SWITCHED_ON} |-> contactor_drive == (state == DSM_SWITCHED_ON))
    else $error("contactor wrong");
  AST_READY_LINE: assert property (
    state == DSM_READY && !flags.line_supply |=> state != DSM_SWITCHED_ON)
    else $error("switched on without line");
  AST_CFG_DROP: assert property (
    state == DSM_SWITCHED_ON && cfg_write && !fault_event |=> s_disabled)
    else $error("config write did not drop state");
  AST_CFG_LOCK: assert property (
    state inside {DSM_OP_ENABLED, DSM_QUICK_STOP} |-> !cfg_write_ok)
    else $error("config accepted while running");
  AST_OPEN_LOOP: assert property (
    state == DSM_OP_ENABLED && open_loop && (reference_zero || halt) |-> !motor_power)
    else $error("open loop powered at zero");
  AST_AUTOTUNE: assert property (
    autotune_start == (autotune_request && state == DSM_OP_ENABLED))
    else $error("autotune start wrong");
  AST_RAMP_HOLD: assert property (
    ramp_stop && !speed_zero && !fault_event && !freewheel_stop && flags.line_supply |=> state == DSM_OP_ENABLED)
    else $error("left before ramp ended");
  AST_QS_AUTO: assert property (s_qs_settled |=> s_disabled)
    else $error("quick stop did not return");
  AST_FAULT: assert property (s_fault_hit |=> state == DSM_FAULT_REACT)
    else $error("fault reaction not entered");
endmodule

bind dsm_drive_state_machine dsm_drive_state_machine_checker u_checker (
  .clock, .rst_b, .flags, .fault_event, .speed_zero, .freewheel_stop, .open_loop, .reference_zero, .halt,
  .quickstop_option, .cfg_write, .autotune_request, .drive_state_word, .state, .output_unlocked,
  .motor_power, .contactor_drive, .ramp_stop, .cfg_write_ok, .autotune_start
);

// ---- dsm_master_model.sv ----
module dsm_master_model (
  // clock
  input  wire logic        clock,
  // command word to the drive
  output logic             cmd_load,
  output logic [15:0]      cmd_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_load = 1'b0;
    cmd_word = 16'h0000;
  end
  // word lines are not held after the load; invert so no stale match
  task automatic send(input logic [15:0] w);
    @(posedge clock);
    cmd_load <= 1'b1;
    cmd_word <= w;
    @(posedge clock);
    cmd_load <= 1'b0;
    cmd_word <= ~w;
  endtask
endmodule

// ---- dsm_drive_state_machine_tb.sv ----
module dsm_drive_state_machine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dsm_pkg::*;
  logic        clock, rst_b, cmd_load, channel_valid, ref_shared, ref_received, fault_event, fault_react_done;
  logic        speed_zero, freewheel_stop, open_loop, reference_zero, halt, disable_op_option;
  logic        cfg_write, adj_write, autotune_request, output_unlocked, motor_power, contactor_drive;
  logic        power_stage_ready, drive_func_active, ramp_stop, fast_stop, coast_stop;
  logic        cfg_write_ok, adj_write_ok, autotune_start;
  logic [2:0]  quickstop_option;
  logic [15:0] cmd_word, drive_state_word;
  dsm_flags_t  flags;
  dsm_state_t  state;
  int          errors, n_compared;

  dsm_master_model u_master (.clock, .cmd_load, .cmd_word);
  dsm_drive_state_machine u_dut (
    .clock, .rst_b, .cmd_load, .cmd_word, .channel_valid, .ref_shared, .ref_received, .flags, .fault_event,
    .fault_react_done, .speed_zero, .freewheel_stop, .open_loop, .reference_zero, .halt, .disable_op_option,
    .quickstop_option, .cfg_write, .adj_write, .autotune_request, .drive_state_word, .state, .output_unlocked,
    .motor_power, .contactor_drive, .power_stage_ready, .drive_func_active, .ramp_stop, .fast_stop,
    .coast_stop, .cfg_write_ok, .adj_write_ok, .autotune_start
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic code(logic [15:0] exp);
    check("state code", drive_state_word & 16'h004F, exp);
  endtask
  task automatic send(logic [15:0] w);
    u_master.send(w);
    cyc(2);
  endtask
  task automatic go_op;
    send(16'h0006);
    send(16'h0007);
    send(16'h000F);
  endtask
  task automatic pulse_cfg(logic exp, logic exp_adj);
    @(posedge clock) {cfg_write, adj_write} <= 2'b11;
    #1;
    check("cfg ok", cfg_write_ok, exp);
    check("adj ok", adj_write_ok, exp_adj);
    @(posedge clock) {cfg_write, adj_write} <= 2'b00;
    cyc(1);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // whole run is under 600 cycles; allow about four times that
  initial begin
    #60us;
    errors++;
    stop_test;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {errors, n_compared} = '0;
    {rst_b, channel_valid, ref_shared, ref_received, fault_event, fault_react_done} = '0;
    {freewheel_stop, open_loop, reference_zero, halt, disable_op_option, cfg_write, adj_write} = '0;
    speed_zero = 1'b0;
    autotune_request = 1'b1;
    quickstop_option = QSOPT_AUTO;
    flags = 7'h40;
    repeat (16) @(posedge clock);
    check("reset word", drive_state_word, SW_RESET);
    rst_b <= 1'b1;
    cyc(3);
    check("init state", state, DSM_NOT_READY);
    code(16'h0040);
    cyc(20);
    check("after init", state, DSM_SW_ON_DIS);
    @(posedge clock) flags <= 7'h7F;
    cyc(2);
    check("flag word", drive_state_word, 16'hCEF0);
    @(posedge clock) flags <= 7'h00;
    $display("test reset and flags done");
    send(16'h0006);
    code(16'h0001);
    send(16'h0007);
    code(16'h0001);
    @(posedge clock) flags <= 7'h40;
    cyc(2);
    code(16'h0003);
    check("power", {contactor_drive, power_stage_ready, output_unlocked, autotune_start}, 4'b1100);
    pulse_cfg(1'b1, 1'b1);
    code(16'h0040);
    $display("test switch on done");
    send(16'h0006);
    send(16'h0007);
    send(16'h000F);
    code(16'h0003);
    @(posedge clock) {channel_valid, ref_shared} <= 2'b11;
    cyc(2);
    code(16'h0003);
    @(posedge clock) ref_received <= 1'b1;
    cyc(2);
    code(16'h0007);
    check("running", {output_unlocked, motor_power, drive_func_active, autotune_start}, 4'hF);
    pulse_cfg(1'b0, 1'b1);
    @(posedge clock) {open_loop, reference_zero} <= 2'b11;
    cyc(1);
    check("open loop power", motor_power, 1'b0);
    @(posedge clock) {open_loop, reference_zero} <= 2'b00;
    $display("test enable done");
    u_master.send(16'h0007);
    #1;
    check("coast", coast_stop, 1'b1);
    cyc(2);
    code(16'h0003);
    check("coast end", coast_stop, 1'b0);
    send(16'h000F);
    @(posedge clock) disable_op_option <= DISOP_RAMP;
    send(16'h0007);
    code(16'h0007);
    check("ramp", {ramp_stop, coast_stop}, 2'b10);
    @(posedge clock) speed_zero <= 1'b1;
    cyc(2);
    code(16'h0003);
    $display("test disable operation done");
    send(16'h000F);
    @(posedge clock) speed_zero <= 1'b0;
    send(16'h0002);
    code(16'h0047);
    check("fast stop", {fast_stop, output_unlocked, motor_power}, 3'b111);
    pulse_cfg(1'b0, 1'b0);
    @(posedge clock) speed_zero <= 1'b1;
    cyc(2);
    code(16'h0040);
    go_op();
    @(posedge clock) quickstop_option <= QSOPT_HOLD;
    send(16'h0002);
    send(16'h000F);
    cyc(4);
    code(16'h0047);
    send(16'h0000);
    code(16'h0040);
    $display("test quick stop done");
    go_op();
    @(posedge clock) fault_event <= 1'b1;
    cyc(2);
    code(16'h000F);
    @(posedge clock) fault_react_done <= 1'b1;
    cyc(2);
    code(16'h0008);
    @(posedge clock) {fault_event, fault_react_done} <= 2'b00;
    send(16'h0000);
    check("fault lock", {output_unlocked, motor_power}, 2'b00);
    send(16'h0080);
    code(16'h0040);
    $display("test fault done");
    stop_test;
  end
endmodule
